// file: lock_clear_pkg.sv
// Constants for the host-side clear-lock sequencer of a parallel NOR flash
package lock_clear_pkg;
  // ****************************************
  // Command codes and status bits
  // ****************************************
  localparam logic [7:0] CMD_CLEAR_SETUP   = 8'h60;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] STATUS_USE_MASK   = 8'hFE;
  localparam int SEQUENCER_IDLE_BIT        = 7;
  localparam int ERASE_LOCKCLEAR_ERR_BIT   = 5;
  localparam int PROGRAM_LOCKSET_ERR_BIT   = 4;
  localparam int SUPPLY_LOW_BIT            = 3;
  localparam int PROTECT_BIT               = 1;
  // ****************************************
  // Host register map
  // ****************************************
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_RESULT  = 2'h2;
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_HV_BIT     = 1;
  localparam int CTRL_POLL_BIT   = 2;
  localparam int CTRL_RESET_BIT  = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STROBE_NS       = 80;
  localparam int STROBE_CYCLES   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_NS  = 200;
  localparam int RESET_CYCLES    = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_SETUP   = 4'b0001,
    ST_GAP     = 4'b0011,
    ST_CONFIRM = 4'b0010,
    ST_WAIT    = 4'b0110,
    ST_POLL    = 4'b0111,
    ST_CHECK   = 4'b0101,
    ST_CLRSR   = 4'b0100,
    ST_ARRAY   = 4'b1100,
    ST_RESET   = 4'b1101
  } state_t;
endpackage : lock_clear_pkg

// file: lock_clear_host.sv
// Host controller that runs the clear-all-block-locks sequence on a NOR flash
`timescale 1ns/1ps
module lock_clear_host
  import lock_clear_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            flash_ce_n,
  output logic            flash_we_n,
  output logic            flash_oe_n,
  output logic      [7:0] flash_dq_out,
  output logic            flash_dq_oe,
  input  wire logic [7:0] flash_dq_in,
  output logic            reset_powerdown_pin_n,
  output logic            high_voltage_request,
  input  wire logic       ready_busy_out
);
  // ****************************************
  // Registers and state
  // ****************************************
  state_t     state;
  logic       use_hv;
  logic       use_poll;
  logic       busy;
  logic       done;
  logic [7:0] last_status;
  logic [2:0] result;
  logic [7:0] strobe_cnt;
  logic       pending_start;
  logic       pending_reset;
  logic [7:0] masked;
  logic [7:0] bus_byte;
  logic       strobe_end;

  assign strobe_end = (strobe_cnt == 8'(STROBE_CYCLES - 1));
  // Reserved bit dropped before any decision
  assign masked = flash_dq_in & STATUS_USE_MASK;

  // ****************************************
  // Software port
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      use_hv        <= 1'b0;
      use_poll      <= 1'b0;
      pending_start <= 1'b0;
      pending_reset <= 1'b0;
    end
    else
    begin
      if (reg_write && reg_addr == REG_CONTROL)
      begin
        use_hv   <= reg_wdata[CTRL_HV_BIT];
        use_poll <= reg_wdata[CTRL_POLL_BIT];
      end
      if (reg_write && reg_addr == REG_CONTROL && reg_wdata[CTRL_START_BIT])
        pending_start <= 1'b1;
      else if (state == ST_SETUP)
        pending_start <= 1'b0;
      if (reg_write && reg_addr == REG_CONTROL && reg_wdata[CTRL_RESET_BIT])
        pending_reset <= 1'b1;
      else if (state == ST_RESET)
        pending_reset <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_read && reg_addr == REG_CONTROL)
      reg_rdata <= {4'h0, 1'b0, use_poll, use_hv, 1'b0};
    else if (reg_read && reg_addr == REG_STATUS)
      reg_rdata <= {5'h00, ready_busy_out, done, busy};
    else if (reg_read && reg_addr == REG_RESULT)
      reg_rdata <= last_status;
    else if (reg_read)
      reg_rdata <= {5'h00, result};
    else
      reg_rdata <= 8'h00;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Each flash write is ce/we low for STROBE_CYCLES - 1 cycles, then high for at least one cycle
  always_comb
  begin
    case (state)
      ST_SETUP:   bus_byte = CMD_CLEAR_SETUP;
      ST_CONFIRM: bus_byte = CMD_CLEAR_CONFIRM;
      ST_CLRSR:   bus_byte = CMD_CLEAR_STATUS;
      ST_ARRAY:   bus_byte = CMD_READ_ARRAY;
      default:    bus_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                 <= ST_IDLE;
      strobe_cnt            <= 8'h00;
      flash_ce_n            <= 1'b1;
      flash_we_n            <= 1'b1;
      flash_oe_n            <= 1'b1;
      flash_dq_out          <= 8'h00;
      flash_dq_oe           <= 1'b0;
      reset_powerdown_pin_n <= 1'b0;
      high_voltage_request  <= 1'b0;
      busy                  <= 1'b0;
      done                  <= 1'b0;
      last_status           <= 8'h00;
      result                <= 3'h0;
    end
    else
    begin
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          reset_powerdown_pin_n <= 1'b1;
          strobe_cnt <= 8'h00;
          if (pending_reset)
            state <= ST_RESET;
          else if (pending_start)
          begin
            busy  <= 1'b1;
            done  <= 1'b0;
            // Master lock set needs high voltage held through the op
            high_voltage_request <= use_hv;
            state <= ST_SETUP;
          end
        end
        ST_SETUP, ST_CONFIRM, ST_CLRSR, ST_ARRAY:
        begin
          flash_ce_n   <= 1'b0;
          flash_we_n   <= 1'b0;
          flash_dq_out <= bus_byte;
          flash_dq_oe  <= 1'b1;
          strobe_cnt   <= strobe_end ? 8'h00 : strobe_cnt + 8'h01;
          if (strobe_end)
          begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            if (state == ST_SETUP)
              state <= ST_GAP;
            else if (state == ST_CONFIRM)
              state <= ST_WAIT;
            else if (state == ST_CLRSR)
              state <= ST_ARRAY;
            else
            begin
              busy  <= 1'b0;
              done  <= 1'b1;
              high_voltage_request <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_GAP:
          state <= ST_CONFIRM;
        ST_WAIT:
        begin
          // Either setting moves on to status polling, which decides completion
          if (use_poll)
            state <= ST_POLL;
          else if (ready_busy_out)
            state <= ST_POLL;
        end
        ST_POLL:
        begin
          // A reset order ends the poll loop; ST_WAIT ignores it but is left before ready_busy_out falls, so a clear is aborted with polling on or off
          if (pending_reset)
          begin
            strobe_cnt <= 8'h00;
            state      <= ST_RESET;
          end
          else
          begin
            // Reads now return status, not array data
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
            strobe_cnt <= strobe_end ? 8'h00 : strobe_cnt + 8'h01;
            if (strobe_end)
            begin
              flash_ce_n <= 1'b1;
              flash_oe_n <= 1'b1;
              state <= ST_CHECK;
              last_status <= masked;
            end
          end
        end
        ST_CHECK:
        begin
          // Other bits mean nothing until idle flag is one
          if (!last_status[SEQUENCER_IDLE_BIT])
            state <= ST_POLL;
          else
          begin
            // Result code: 1 ok, 2 bad sequence, 3 supply low, 4 protected
            if (last_status[ERASE_LOCKCLEAR_ERR_BIT] && last_status[PROGRAM_LOCKSET_ERR_BIT])
              result <= 3'h2;
            else if (last_status[SUPPLY_LOW_BIT])
              result <= 3'h3;
            else if (last_status[PROTECT_BIT])
              result <= 3'h4;
            else
              result <= 3'h1; // All locks cleared at once
            state <= ST_CLRSR;
          end
        end
        ST_RESET:
        begin
          // Pulse the reset pin; device drops status and aborts
          reset_powerdown_pin_n <= 1'b0;
          high_voltage_request  <= 1'b0;
          strobe_cnt <= strobe_cnt + 8'h01;
          if (strobe_cnt == 8'(RESET_CYCLES - 1))
          begin
            strobe_cnt <= 8'h00;
            // An aborted clear leaves locks unknown, so flag for a retry
            if (busy)
              result <= 3'h5;
            busy  <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  confirm_follows_setup_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_GAP) |=> (state == ST_CONFIRM))
    else $error("confirm did not follow setup");
  confirm_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_CONFIRM && !flash_we_n && flash_dq_oe) |-> (flash_dq_out == CMD_CLEAR_CONFIRM))
    else $error("wrong confirm code on bus");
  read_array_last_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(busy) && done) |-> $past(state) == ST_ARRAY)
    else $error("finished without read-array");
  idle_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_CHECK && !last_status[SEQUENCER_IDLE_BIT]) |=> (state == ST_POLL))
    else $error("status used while busy");
  reserved_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_CHECK) |-> !last_status[0])
    else $error("reserved bit not masked");
  clear_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_CHECK && last_status[SEQUENCER_IDLE_BIT]) |=> (state == ST_CLRSR))
    else $error("status not cleared after check");
  bad_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_CHECK && last_status[7] && last_status[5] && last_status[4]) |=> (result == 3'h2))
    else $error("bad sequence not reported");
  no_poll_early_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_WAIT && !use_poll && !ready_busy_out) |=> (state == ST_WAIT))
    else $error("left wait while device busy");
endmodule : lock_clear_host

// file: flash_model.sv
// Behavioural flash device that answers the clear-lock sequence
`timescale 1ns/1ps
module flash_model
  import lock_clear_pkg::*;
#(
  parameter int BUSY_CYCLES = 12
)
(
  input  wire logic        tick,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic  [7:0] din,
  input  wire logic        rp_n,
  input  wire logic        hv,
  input  wire logic        supply_low,
  input  wire logic        set_master,
  output logic       [7:0] dout,
  output logic             rdy,
  output logic      [31:0] locks,
  output logic             array_mode
);
  logic [7:0] sr_q;
  logic [7:0] cap;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic       wr_act;
  logic       setup;
  logic       master_q = 1'b0;
  int         left;
  initial locks = 32'hFFFF0F0F;
  // ****************
  // Write decoding
  // ****************
  // A write is taken when the strobes rise, so the data of the whole cycle is kept
  always @(posedge tick or negedge rp_n)
    if (!rp_n)
    begin
      if (left > 0)
        locks <= 32'h5A5A5A5A;
      sr_q <= 8'h00;
      left <= 0;
      setup <= 1'b0;
      wr_act <= 1'b0;
      array_mode <= 1'b1;
    end
    else
    begin
      if (set_master)
        master_q <= 1'b1;
      wr_act <= !ce_n && !we_n;
      if (!ce_n && !we_n)
        cap <= din;
      if (left == 1)
        locks <= 32'h0;
      if (left > 0)
        left <= left - 1;
      if (wr_act && we_n)
      begin
        array_mode <= 1'b0;
        setup <= 1'b0;
        if (setup)
        begin
          if (cap !== CMD_CLEAR_CONFIRM)
            sr_q[5:4] <= 2'b11;
          else if (supply_low)
            sr_q <= sr_q | 8'h28;
          else if (master_q && !hv)
            sr_q <= sr_q | 8'h22;
          else
            left <= BUSY_CYCLES;
        end
        else if (cap == CMD_CLEAR_SETUP)
          setup <= 1'b1;
        else if (cap == CMD_CLEAR_STATUS)
          sr_q <= 8'h00;
        else if (cap == CMD_READ_ARRAY)
          array_mode <= 1'b1;
      end
    end
  assign rdy = (left == 0);
  // Reserved bit reads one so a host that forgets the mask is caught
  assign val = array_mode ? 8'h3C : (left > 0 ? {1'b0, ~sr_q[6:0]} : {1'b1, sr_q[6:1], 1'b1});
  // Released bus shows the inverse of the last byte, never a held value
  assign dout = (!ce_n && !oe_n) ? val : ~last;
  always @(posedge tick)
    if (!ce_n && !oe_n)
      last <= val;
endmodule : flash_model

// file: lock_clear_host_test.sv
// Testbench for the clear-lock host controller
`timescale 1ns/1ps
module lock_clear_host_test;
  import lock_clear_pkg::*;
  logic        ref_clk, rst_n, reg_write, reg_read, supply_low, set_master, array_mode;
  logic        flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, reset_powerdown_pin_n;
  logic        high_voltage_request, ready_busy_out;
  logic  [1:0] reg_addr;
  logic  [7:0] reg_wdata, reg_rdata, flash_dq_out, dev_dq, bus;
  logic [31:0] locks;
  int          fail_count, check_count;
  int          cycles = 0;
  assign bus = flash_dq_oe ? flash_dq_out : dev_dq;
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  lock_clear_host i_lock_clear_host (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(bus),
    .reset_powerdown_pin_n(reset_powerdown_pin_n), .high_voltage_request(high_voltage_request),
    .ready_busy_out(ready_busy_out));
  flash_model #(.BUSY_CYCLES(12)) i_flash_model (.tick(ref_clk), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .din(bus), .rp_n(reset_powerdown_pin_n), .hv(high_voltage_request),
    .supply_low(supply_low), .set_master(set_master), .dout(dev_dq), .rdy(ready_busy_out),
    .locks(locks), .array_mode(array_mode));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Start one clear-lock run, wait for done, then judge code and kept status
  task automatic run(input logic [7:0] ctl, input logic [7:0] code, input logic [7:0] res);
    logic [7:0] s;
    int         n;
    wr(REG_CONTROL, ctl);
    s = 8'h01;
    n = 0;
    while (s[1:0] !== 2'b10 && n < 300)
    begin
      rd(REG_STATUS, s);
      n++;
    end
    chk(s[1:0], 2'b10);
    rd(2'h3, s);
    chk(s, code);
    rd(REG_RESULT, s);
    chk(s, res);
  endtask : run
  // ****************
  // Scenarios
  // ****************
  task automatic t_after_reset;
    logic [7:0] s;
    rd(REG_STATUS, s);
    chk(s, 8'h04);
    chk(array_mode, 1'b1);
  endtask : t_after_reset
  task automatic t_supply_low;
    @(posedge ref_clk);
    supply_low <= 1'b1;
    run(8'h01, 8'h03, 8'hA8);
    chk(locks, 32'hFFFF0F0F);
    @(posedge ref_clk);
    supply_low <= 1'b0;
  endtask : t_supply_low
  task automatic t_unlocked;
    logic [7:0] s;
    run(8'h01, 8'h01, 8'h80);
    chk(locks, 32'h0);
    chk(array_mode, 1'b1);
    wr(2'h3, 8'hFF);
    rd(2'h3, s);
    chk(s, 8'h01);
  endtask : t_unlocked
  task automatic t_protected;
    @(posedge ref_clk);
    set_master <= 1'b1;
    @(posedge ref_clk);
    set_master <= 1'b0;
    run(8'h01, 8'h04, 8'hA2);
  endtask : t_protected
  task automatic t_high_voltage;
    run(8'h07, 8'h01, 8'h80);
    chk(array_mode, 1'b1);
  endtask : t_high_voltage
  // Reset order while the device is busy, polling off, aborts the clear with code 5; a repeat restores known locks
  task automatic t_abort;
    logic [7:0] s;
    int         n;
    wr(REG_CONTROL, 8'h03);
    n = 0;
    while (ready_busy_out && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(ready_busy_out, 1'b0);
    wr(REG_CONTROL, 8'h08);
    repeat (12) @(posedge ref_clk);
    rd(2'h3, s);
    chk(s, 8'h05);
    chk(locks, 32'h5A5A5A5A);
    chk(array_mode, 1'b1);
    run(8'h03, 8'h01, 8'h80);
    chk(locks, 32'h0);
  endtask : t_abort
  task automatic conclude;
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    supply_low = 1'b0;
    set_master = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_after_reset();
    t_supply_low();
    t_unlocked();
    t_protected();
    t_high_voltage();
    t_abort();
    conclude();
  end
endmodule : lock_clear_host_test
